/* inc/acc_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing
//          counts of the converter control block.
// Assumes: Byte-wide registers on an 8-bit address port.
// Notes:   Definitions only.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ============================================================
// Register offsets
`define ACC_CSR_ADDR    8'h34
`define ACC_RES_ADDR    8'h35
`define ACC_AMP_ADDR    8'h36
`define ACC_STS_ADDR    8'h37
`define ACC_MSK_ADDR    8'h38

// ============================================================
// Field positions
`define ACC_CSR_DONE    7
`define ACC_CSR_SPEED   6
`define ACC_CSR_ON      5
`define ACC_AMP_SLOW    3
`define ACC_AMP_GAIN    2
`define ACC_STS_OVR     0
`define ACC_STS_ABT     1

// ============================================================
// Reset values, read masks and channel limit
`define ACC_REG_RST     8'h00
`define ACC_AMP_MASK    8'h0C
`define ACC_CH_MAX      3'h4

// ============================================================
// Timing counts, in converter clock ticks
`define ACC_SAMPLE_TICKS 3'h4
`define ACC_STEP_TICKS   3'h4

`endif

/* inc/acc_pkg.sv */
// Purpose: Types shared by the converter control block.
// Assumes: Nothing beyond the register header.
// Notes:   One-hot state codes.
package acc_pkg;

    // ============================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ACC_ST_OFF  = 3'b001,
        ACC_ST_SAMP = 3'b010,
        ACC_ST_CONV = 3'b100
    } acc_state_t;

    typedef logic [7:0] acc_byte_t;

endpackage

/* src/acc_conv_ctrl.sv */
// Purpose: Control of an 8-bit successive-approximation converter:
//          register file, clock divider, sample and step sequencer.
// Assumes: Comparator and pin levels are asynchronous to clock_i.
// Notes:   The analog sample-and-hold and comparator sit outside.
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_conv_ctrl
    import acc_pkg::*;
(
    input  wire logic            clock_i,
    input  wire logic            reset_i,
    input  wire logic            clk_en_i,
    input  wire logic [7:0]      addr_i,
    input  wire acc_pkg::acc_byte_t wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output acc_pkg::acc_byte_t   rdata_o,
    output logic                 irq_o,
    input  wire logic            halt_i,
    input  wire logic            wait_i,
    input  wire logic            cmp_i,
    input  wire logic [4:0]      pin_level_i,
    output logic [4:0]           pin_level_o,
    output logic                 fe_power_o,
    output logic                 fe_sample_o,
    output logic [2:0]           fe_chan_o,
    output logic                 fe_gain_o,
    output acc_pkg::acc_byte_t   fe_trial_o
);
    import acc_pkg::*;

    // ============================================================
    // Registers
    acc_state_t st_ff;
    acc_state_t nxt_st;
    logic       speed_ff;
    logic       on_ff;
    logic [2:0] chan_ff;
    logic       done_ff;
    acc_byte_t  result_ff;
    logic       slow_ff;
    logic       gain_ff;
    logic [1:0] sts_ff;
    logic [1:0] mask_ff;
    acc_byte_t  rdata_ff;
    logic       irq_ff;
    logic [1:0] div_ff;
    logic [2:0] tick_cnt_ff;
    logic [2:0] bit_ff;
    acc_byte_t  sar_ff;
    logic       power_ff;
    logic       cmp_s1_ff;
    logic       cmp_s2_ff;
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;

    // ============================================================
    // Bus decode
    wire csr_sel = (addr_i == `ACC_CSR_ADDR);
    wire res_sel = (addr_i == `ACC_RES_ADDR);
    wire amp_sel = (addr_i == `ACC_AMP_ADDR);
    wire sts_sel = (addr_i == `ACC_STS_ADDR);
    wire msk_sel = (addr_i == `ACC_MSK_ADDR);
    wire csr_wr  = wr_i & csr_sel;
    wire amp_wr  = wr_i & amp_sel;
    wire msk_wr  = wr_i & msk_sel;
    wire res_rd  = rd_i & res_sel;
    wire sts_rd  = rd_i & sts_sel;

    // Wait mode is deliberately ignored: the converter keeps running.
    wire wait_unused = wait_i;

    // Halt overrides the on bit so the converter is off while halted.
    wire run_now = on_ff & ~halt_i;
    wire new_on  = wdata_i[`ACC_CSR_ON];
    wire run_nxt = csr_wr ? (new_on & ~halt_i) : run_now;

    // ============================================================
    // Converter clock divider
    wire new_slow  = amp_wr ? wdata_i[`ACC_AMP_SLOW] : slow_ff;
    wire [1:0] div_top = slow_ff  ? 2'h3 :
                         speed_ff ? 2'h0 : 2'h1;
    wire tick = (div_ff >= div_top);
    wire [1:0] nxt_div = tick ? 2'h0 : 2'(div_ff + 2'h1);

    // ============================================================
    // Sequencer decode
    wire conv_now  = (st_ff == ACC_ST_CONV);
    wire samp_now  = (st_ff == ACC_ST_SAMP);
    wire tick_last = tick & (tick_cnt_ff ==
                     (samp_now ? 3'(`ACC_SAMPLE_TICKS - 3'h1)
                               : 3'(`ACC_STEP_TICKS - 3'h1)));
    wire step_end  = conv_now & tick_last;
    wire [7:0] bit_mask = 8'h01 << bit_ff;
    // Comparator high means the input is at or above the trial code.
    wire [7:0] sar_keep = cmp_s2_ff ? sar_ff
                                    : (sar_ff & ~bit_mask);
    wire [7:0] next_mask = 8'h01 << 3'(bit_ff - 3'h1);
    // An abort in the same cycle discards the finishing conversion.
    wire abort   = csr_wr & (st_ff != ACC_ST_OFF);
    wire done_ev = step_end & (bit_ff == 3'h0) & ~csr_wr;
    wire ovr_ev  = done_ev & done_ff;
    wire [1:0] ev = {abort, ovr_ev};

    // ============================================================
    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ACC_ST_OFF: begin
                if (run_nxt) begin
                    nxt_st = ACC_ST_SAMP;
                end
            end
            ACC_ST_SAMP: begin
                if (tick_last) begin
                    nxt_st = ACC_ST_CONV;
                end
            end
            ACC_ST_CONV: begin
                if (done_ev) begin
                    nxt_st = ACC_ST_SAMP;
                end
            end
            default: begin
                nxt_st = ACC_ST_OFF;
            end
        endcase
        if (!run_nxt) begin
            nxt_st = ACC_ST_OFF;
        end else if (csr_wr) begin
            nxt_st = ACC_ST_SAMP;
        end
    end

    wire restart = csr_wr | (st_ff != nxt_st);
    wire [2:0] nxt_tick_cnt = restart ? 3'h0 :
                              tick_last ? 3'h0 :
                              tick ? 3'(tick_cnt_ff + 3'h1) : tick_cnt_ff;

    wire [2:0] nxt_bit = (nxt_st != ACC_ST_CONV) ? 3'h7 :
                         step_end ? 3'(bit_ff - 3'h1) : bit_ff;
    wire [7:0] nxt_sar = (nxt_st != ACC_ST_CONV) ? 8'h80 :
                         step_end ? (sar_keep | next_mask) : sar_ff;

    wire nxt_done = done_ev | (done_ff & ~(csr_wr | res_rd));
    wire [1:0] nxt_sts = ev | (sts_ff & ~{2{sts_rd}});
    wire [1:0] nxt_mask = msk_wr ? wdata_i[1:0] : mask_ff;

    // ============================================================
    // Read data
    wire [7:0] csr_view = {done_ff, speed_ff, on_ff, 2'h0, chan_ff};
    wire [7:0] amp_view = {4'h0, slow_ff, gain_ff, 2'h0};
    wire [7:0] rd_mux = csr_sel ? csr_view :
                        res_sel ? result_ff :
                        amp_sel ? amp_view :
                        sts_sel ? {6'h00, sts_ff} :
                        msk_sel ? {6'h00, mask_ff} : 8'h00;

    // ============================================================
    // Synchronisers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
            pin_s1_ff <= 5'h00;
            pin_s2_ff <= 5'h00;
        end else if (clk_en_i) begin
            cmp_s1_ff <= cmp_i;
            cmp_s2_ff <= cmp_s1_ff;
            pin_s1_ff <= pin_level_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ============================================================
    // Software registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            speed_ff <= 1'b0;
            on_ff    <= 1'b0;
            chan_ff  <= 3'h0;
            slow_ff  <= 1'b0;
            gain_ff  <= 1'b0;
            mask_ff  <= 2'h0;
        end else if (clk_en_i) begin
            if (csr_wr) begin
                speed_ff <= wdata_i[`ACC_CSR_SPEED];
                on_ff    <= new_on;
                chan_ff  <= wdata_i[2:0];
            end
            if (amp_wr) begin
                slow_ff <= new_slow;
                gain_ff <= wdata_i[`ACC_AMP_GAIN];
            end
            mask_ff <= nxt_mask;
        end
    end

    // ============================================================
    // Flags, result and read port
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            done_ff   <= 1'b0;
            result_ff <= `ACC_REG_RST;
            sts_ff    <= 2'h0;
            irq_ff    <= 1'b0;
            rdata_ff  <= `ACC_REG_RST;
        end else if (clk_en_i) begin
            done_ff <= nxt_done;
            if (done_ev) begin
                result_ff <= sar_keep;
            end
            sts_ff   <= nxt_sts;
            irq_ff   <= |(nxt_sts & nxt_mask);
            rdata_ff <= rd_i ? rd_mux : 8'h00;
        end
    end

    // ============================================================
    // Sequencer
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff       <= ACC_ST_OFF;
            div_ff      <= 2'h0;
            tick_cnt_ff <= 3'h0;
            bit_ff      <= 3'h7;
            sar_ff      <= 8'h80;
            power_ff    <= 1'b0;
        end else if (clk_en_i) begin
            st_ff       <= nxt_st;
            div_ff      <= restart ? 2'h0 : nxt_div;
            tick_cnt_ff <= nxt_tick_cnt;
            bit_ff      <= nxt_bit;
            sar_ff      <= nxt_sar;
            power_ff    <= (nxt_st != ACC_ST_OFF);
        end
    end

    // ============================================================
    // Outputs
    assign rdata_o     = rdata_ff;
    assign irq_o       = irq_ff;
    assign pin_level_o = pin_s2_ff;
    assign fe_power_o  = power_ff;
    assign fe_sample_o = st_ff[1];
    assign fe_chan_o   = chan_ff;
    assign fe_gain_o   = gain_ff;
    assign fe_trial_o  = sar_ff;

    // ============================================================
    // Assertions
    default clocking acc_cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // Counts approximation steps apart from the bit index, so that the
    // eight-step check does not lean on the logic it guards.
    logic [3:0] steps_ff;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            steps_ff <= 4'h0;
        end else if (clk_en_i) begin
            steps_ff <= !conv_now ? 4'h0 : 4'(steps_ff + {3'h0, step_end});
        end
    end

    a_off_when_clear: assert property (
        (clk_en_i && !run_nxt) |=> (!fe_power_o && st_ff == ACC_ST_OFF))
        else $error("Converter still powered after switch-off.");

    a_start_on_set: assert property (
        (clk_en_i && csr_wr && new_on && !halt_i)
            |=> (fe_power_o && fe_sample_o))
        else $error("Setting the on bit did not start sampling.");

    a_done_sets: assert property (
        (clk_en_i && done_ev) |=> done_ff)
        else $error("Conversion end did not set the done flag.");

    a_result_stable: assert property (
        (clk_en_i && !done_ev) |=> $stable(result_ff))
        else $error("Result changed without a conversion end.");

    a_done_clears: assert property (
        (clk_en_i && done_ff && !done_ev && (csr_wr || res_rd))
            |=> !done_ff)
        else $error("Done flag not cleared by access.");

    a_abort_restart: assert property (
        (clk_en_i && conv_now && csr_wr && new_on && !halt_i)
            |=> (fe_sample_o && !done_ff))
        else $error("Control write did not restart conversion.");

    a_full_rate: assert property (
        (clk_en_i && samp_now && speed_ff && !slow_ff && !restart
            && !tick_last)
            |=> (tick_cnt_ff == 3'($past(tick_cnt_ff) + 3'h1)))
        else $error("Full rate did not tick every cycle.");

    a_halt_off: assert property (
        (clk_en_i && halt_i) |=> !fe_power_o)
        else $error("Converter powered during halt.");

    a_gain_zero: assert property (
        (clk_en_i && rd_i && amp_sel) |=> ((rdata_o & 8'hF3) == 8'h00))
        else $error("Unused gain register bits read nonzero.");

    a_eight_steps: assert property (
        (clk_en_i && done_ev) |-> (steps_ff == 4'h7))
        else $error("Conversion ended before its last step.");

    c_conv_done: cover property (clk_en_i && done_ev);
    c_abort: cover property (clk_en_i && abort && conv_now);
    c_overrun: cover property (clk_en_i && ovr_ev);
    c_halt_stop: cover property (clk_en_i && halt_i && conv_now);

endmodule
`default_nettype wire

/* verification/acc_front_end_model.sv */
// Purpose: Behavioural analog front end: sample-and-hold and comparator.
// Assumes: Each input pin carries a fixed level code; gain multiplies by 8.
// Notes:   While powered down the comparator output toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module acc_front_end_model (
    input  wire logic       clock_i,
    input  wire logic       fe_power_i,
    input  wire logic       fe_sample_i,
    input  wire logic [2:0] fe_chan_i,
    input  wire logic       fe_gain_i,
    input  wire logic [7:0] fe_trial_i,
    output logic            cmp_o
);
    // ============================================================
    // Input levels and hold capacitor
    logic [7:0]  level [0:4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h13};
    logic [7:0]  picked;
    logic [10:0] amp;
    logic [7:0]  held_ff = 8'h00;
    logic        idle_ff = 1'b0;
    assign picked = (fe_chan_i <= 3'h4) ? level[fe_chan_i] : 8'h00;
    assign amp    = fe_gain_i ? {picked, 3'h0} : {3'h0, picked};
    // The held level only follows the pin during sampling, so a late
    // channel change cannot leak into a conversion in progress.
    always @(posedge clock_i) begin
        idle_ff <= ~idle_ff;
        if (fe_sample_i) begin
            held_ff <= (amp > 11'h0FF) ? 8'hFF : amp[7:0];
        end
    end
    assign cmp_o = fe_power_i ? (held_ff >= fe_trial_i) : idle_ff;
endmodule
`default_nettype wire

/* verification/adc_conversion_control_test.sv */
// Purpose: Self-checking bench of the converter control block.
// Assumes: Default rate settings outside t_rate; front end model answers at once.
// Notes:   Clock enable drops once, to show that a control write is then ignored.
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module adc_conversion_control_test;
    import acc_pkg::*;
    // ============================================================
    // Signals
    logic       clock_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       clk_en_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    acc_byte_t  wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       halt_i = 1'b0;
    logic       wait_i = 1'b0;
    logic [4:0] pin_level_i = 5'h00;
    acc_byte_t  rdata_o;
    acc_byte_t  fe_trial_o;
    logic       irq_o, cmp_i, fe_power_o, fe_sample_o, fe_gain_o;
    logic [2:0] fe_chan_o;
    logic [4:0] pin_level_o;
    int         bad_count = 0;
    int         n_tests = 0;
    acc_byte_t  expect_res [0:4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h13};

    acc_conv_ctrl acc_conv_ctrl_inst (.clock_i(clock_i), .reset_i(reset_i),
        .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .halt_i(halt_i),
        .wait_i(wait_i), .cmp_i(cmp_i), .pin_level_i(pin_level_i),
        .pin_level_o(pin_level_o), .fe_power_o(fe_power_o),
        .fe_sample_o(fe_sample_o), .fe_chan_o(fe_chan_o),
        .fe_gain_o(fe_gain_o), .fe_trial_o(fe_trial_o));
    acc_front_end_model acc_front_end_model_inst (.clock_i(clock_i),
        .fe_power_i(fe_power_o), .fe_sample_i(fe_sample_o),
        .fe_chan_i(fe_chan_o), .fe_gain_i(fe_gain_o),
        .fe_trial_i(fe_trial_o), .cmp_o(cmp_i));

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // ============================================================
    // Shared tasks
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input acc_byte_t got, input acc_byte_t exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask
    // Reserved control bits are written as zero by callers, except the 8'hFF writes in t_regs.
    task automatic wr(input logic [7:0] a, input acc_byte_t d);
        @(posedge clock_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clock_i); wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output acc_byte_t d);
        @(posedge clock_i); addr_i <= a; rd_i <= 1'b1;
        @(posedge clock_i); rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_done;
        acc_byte_t s;
        s = 8'h00;
        for (int i = 0; i < 200 && s[7] !== 1'b1; i++) rd(`ACC_CSR_ADDR, s);
        if (s[7] !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: done never set", $time);
            finish_test();
        end
    endtask

    // ============================================================
    // Scenarios
    task automatic t_regs;
        acc_byte_t d;
        rd(`ACC_CSR_ADDR, d); chk(d, 8'h00, "csr reset");
        rd(`ACC_RES_ADDR, d); chk(d, 8'h00, "result reset");
        rd(`ACC_AMP_ADDR, d); chk(d, 8'h00, "amp reset");
        wr(`ACC_AMP_ADDR, 8'hFF);
        rd(`ACC_AMP_ADDR, d); chk(d, 8'h0C, "amp mask");
        wr(`ACC_RES_ADDR, 8'hFF);
        rd(`ACC_RES_ADDR, d); chk(d, 8'h00, "result read only");
        wr(8'h40, 8'hFF);
        rd(8'h40, d); chk(d, 8'h00, "unmapped");
        wr(`ACC_AMP_ADDR, 8'h00);
        $display("test regs ended");
    endtask
    task automatic t_chan;
        acc_byte_t d;
        wait_i <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            wr(`ACC_CSR_ADDR, 8'(c));
            wr(`ACC_CSR_ADDR, 8'h20 | 8'(c));
            wait_done();
            chk({5'h0, fe_chan_o}, 8'(c), "channel");
            chk({7'h0, irq_o}, 8'h00, "no irq");
            rd(`ACC_RES_ADDR, d); chk(d, expect_res[c], "result");
            rd(`ACC_CSR_ADDR, d); chk(d, 8'h20 | 8'(c), "read clr");
        end
        @(posedge clock_i); wait_i <= 1'b0;
        $display("test channels ended");
    endtask
    task automatic t_rate;
        acc_byte_t cs [0:3] = '{8'h60, 8'h20, 8'h20, 8'h60};
        acc_byte_t am [0:3] = '{8'h00, 8'h00, 8'h08, 8'h08};
        int        rt [0:3] = '{1, 2, 4, 4};
        int        n;
        for (int k = 0; k < 4; k++) begin
            wr(`ACC_AMP_ADDR, am[k]);
            wr(`ACC_CSR_ADDR, cs[k]);
            n = 0;
            for (int i = 0; i < 100; i++) begin
                @(posedge clock_i); #1;
                if (fe_sample_o === 1'b1) n++;
                else if (n > 0) break;
            end
            // The first sampling cycle starts on the last edge of the write task and is not counted.
            chk({7'h0, n == `ACC_SAMPLE_TICKS * rt[k] - 1}, 8'h01,
                "sample length");
            wr(`ACC_CSR_ADDR, 8'h00);
        end
        wr(`ACC_AMP_ADDR, 8'h00);
        $display("test rates ended");
    endtask
    task automatic t_gain;
        acc_byte_t d;
        wr(`ACC_AMP_ADDR, 8'h04);
        wr(`ACC_CSR_ADDR, 8'h24);
        wait_done();
        chk({7'h0, fe_gain_o}, 8'h01, "gain route");
        rd(`ACC_RES_ADDR, d); chk(d, 8'h98, "gain result");
        wr(`ACC_AMP_ADDR, 8'h00);
        $display("test gain ended");
    endtask
    task automatic t_abort;
        acc_byte_t d;
        wr(`ACC_MSK_ADDR, 8'h02);
        wr(`ACC_CSR_ADDR, 8'h21);
        wait_done();
        rd(`ACC_STS_ADDR, d);
        // Leaving done set across the next conversion end makes an overrun,
        // and the later control write then lands in the approximation phase.
        repeat (80) @(posedge clock_i);
        rd(`ACC_STS_ADDR, d); chk(d & 8'h01, 8'h01, "overrun status");
        wr(`ACC_CSR_ADDR, 8'h21);
        @(posedge clock_i); #1;
        chk({7'h0, fe_sample_o}, 8'h01, "restart sample");
        rd(`ACC_CSR_ADDR, d); chk(d, 8'h21, "write clears done");
        chk({7'h0, irq_o}, 8'h01, "abort irq");
        rd(`ACC_STS_ADDR, d); chk(d & 8'h02, 8'h02, "abort status");
        @(posedge clock_i); #1;
        chk({7'h0, irq_o}, 8'h00, "irq cleared");
        $display("test abort ended");
    endtask
    task automatic t_power;
        acc_byte_t d;
        @(posedge clock_i); halt_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1 chk({7'h0, fe_power_o}, 8'h00, "halt off");
        @(posedge clock_i); halt_i <= 1'b0;
        wr(`ACC_CSR_ADDR, 8'h00);
        repeat (200) @(posedge clock_i);
        rd(`ACC_CSR_ADDR, d); chk(d, 8'h00, "off no done");
        chk({7'h0, fe_power_o}, 8'h00, "power off");
        $display("test power ended");
    endtask
    task automatic t_pins;
        logic [4:0] p [0:1] = '{5'h15, 5'h0A};
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_i); pin_level_i <= p[k];
            repeat (3) @(posedge clock_i);
            #1 chk({3'h0, pin_level_o}, {3'h0, p[k]}, "pin level");
        end
        $display("test pins ended");
    endtask
    task automatic t_freeze;
        acc_byte_t d;
        @(posedge clock_i); clk_en_i <= 1'b0;
        wr(`ACC_CSR_ADDR, 8'h20);
        #1 chk({7'h0, fe_power_o}, 8'h00, "frozen write");
        @(posedge clock_i); clk_en_i <= 1'b1;
        rd(`ACC_CSR_ADDR, d); chk(d, 8'h00, "frozen csr");
        $display("test freeze ended");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        t_regs();
        t_chan();
        t_rate();
        t_gain();
        t_abort();
        t_power();
        t_pins();
        t_freeze();
        finish_test();
    end
endmodule
`default_nettype wire
